// ===== core/fault_detect.sv
// selects and optionally synchronises the shutdown fault source
`include "pwm_shutdown_params.svh"
module fault_detect
	import pwm_shutdown_pkg::*;
(
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic clk_en,
	// fault inputs
	input  wire logic comparator_one_async_output,
	input  wire logic comparator_two_async_output,
	input  wire logic fault_input_pin,
	input  wire logic timer1_sync_strobe,
	// control and result
	fault_if.det      fif
);
	logic cmp1_q;
	logic cmp2_q;
	logic cond_q;
	wire  cmp1;
	wire  cmp2;
	wire  flt;
	wire  cond_d;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmp1_q <= 1'b0;
			cmp2_q <= 1'b0;
		end else if (clk_en && timer1_sync_strobe) begin
			cmp1_q <= comparator_one_async_output;
			cmp2_q <= comparator_two_async_output;
		end
	end

	assign cmp1 = fif.comparator_one_sync_enable ? cmp1_q : comparator_one_async_output;
	assign cmp2 = fif.comparator_two_sync_enable ? cmp2_q : comparator_two_async_output;
	assign flt  = ~fault_input_pin;

	assign cond_d = (fif.source_select == `SRC_CMP1)       ? cmp1 :
	                (fif.source_select == `SRC_CMP2)       ? cmp2 :
	                (fif.source_select == `SRC_CMP_ANY)    ? (cmp1 | cmp2) :
	                (fif.source_select == `SRC_FAULT)      ? flt :
	                (fif.source_select == `SRC_FAULT_CMP1) ? (flt | cmp1) :
	                (fif.source_select == `SRC_FAULT_CMP2) ? (flt | cmp2) :
	                (fif.source_select == `SRC_FAULT_ANY)  ? (flt | cmp1 | cmp2) :
	                1'b0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cond_q <= 1'b0;
		end else if (clk_en) begin
			cond_q <= cond_d;
		end
	end

	assign fif.condition = cond_q;
endmodule : fault_detect

// ===== core/fault_if.sv
// fault source selection between control logic and fault detector
interface fault_if;
	import pwm_shutdown_pkg::*;
	src_sel_t source_select;
	logic     comparator_one_sync_enable;
	logic     comparator_two_sync_enable;
	logic     condition;
	modport ctrl (output source_select, output comparator_one_sync_enable,
		output comparator_two_sync_enable, input condition);
	modport det (input source_select, input comparator_one_sync_enable,
		input comparator_two_sync_enable, output condition);
endinterface : fault_if

// ===== core/pwm_auto_shutdown.sv
// auto-shutdown control for a four-pin pwm channel with axi4-lite registers
//
// How it works
// - with auto-restart on, the event flag sets on a fault and clears itself once the fault is gone.
// - with auto-restart off, the flag stays set until software clears it, and pwm resumes only then.
// - while the flag is set all pwm pins show their shutdown state, otherwise they follow the pwm.
// - the three-bit source select in bits 6 to 4 picks the fault source; zero selects none, so only a bit 7 write of one can force shutdown.
// - codes one, two and three trip on comparator one high, comparator two high, or either high.
// - code four trips whenever the fault pin is low.
// - codes five to seven trip on fault pin low or comparator one, comparator two, or either high.
// - bits 3 to 2 give pins a and c a shutdown state of low, high, or tri-state for upper bit set.
// - bits 1 to 0 give pins b and d a shutdown state of low, high, or tri-state for upper bit set.
// - a comparator with sync enabled is sampled on the timer1 strobe before it can trip shutdown.
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`include "pwm_shutdown_params.svh"
module pwm_auto_shutdown
	import pwm_shutdown_pkg::*;
(
	// clock, reset, enable
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        clk_en,
	// axi4-lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// fault sources
	input  wire logic        comparator_one_async_output,
	input  wire logic        comparator_two_async_output,
	input  wire logic        fault_input_pin,
	input  wire logic        timer1_sync_strobe,
	// pwm from the modulator
	input  wire logic [3:0]  pwm_in,
	// pwm pins a, b, c, d in bits 0..3
	output logic [3:0]       pwm_output,
	output logic [3:0]       pwm_output_oe_n,
	// status
	output logic             shutdown_active,
	output logic             irq
);
	// pin positions within pwm_output
	localparam int A = 0;
	localparam int B = 1;
	localparam int C = 2;
	localparam int D = 3;

	fault_if fif ();

	reg8_t      ctrl_q;
	reg8_t      sync_q;
	reg8_t      stat_q;
	reg8_t      mask_q;
	logic       flag_q;
	logic       aw_got_q;
	logic       w_got_q;
	logic [7:0] awaddr_q;
	logic [7:0] wdata_q;
	logic       wstrb0_q;
	logic       awready_q;
	logic       wready_q;
	logic       bvalid_q;
	logic [1:0] bresp_q;
	logic       arready_q;
	logic       rvalid_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;
	logic [3:0] pout_q;
	logic [3:0] poe_n_q;
	logic       irq_q;
	logic       flag_d;

	// write channel bookkeeping
	// address and data may come in either order; a lone one is parked until its partner arrives
	wire aw_hs    = s_axi_awvalid & awready_q;
	wire w_hs     = s_axi_wvalid & wready_q;
	wire aw_have  = aw_got_q | aw_hs;
	wire w_have   = w_got_q | w_hs;
	wire do_write = aw_have & w_have & ~bvalid_q;
	wire [7:0] waddr = aw_hs ? s_axi_awaddr : awaddr_q;
	wire [7:0] wdat  = w_hs ? s_axi_wdata[7:0] : wdata_q;
	wire       wlane = w_hs ? s_axi_wstrb[0] : wstrb0_q;

	wire wr_ctrl = do_write & wlane & (waddr == `OFS_SHUTDOWN_CONTROL);
	wire wr_sync = do_write & wlane & (waddr == `OFS_SYNC_CONTROL);
	wire wr_stat = do_write & wlane & (waddr == `OFS_IRQ_STATUS);
	wire wr_mask = do_write & wlane & (waddr == `OFS_IRQ_MASK);
	// unmapped offsets are answered with an error and change nothing
	wire w_mapped = (waddr == `OFS_SHUTDOWN_CONTROL) | (waddr == `OFS_SYNC_CONTROL) |
	                (waddr == `OFS_IRQ_STATUS) | (waddr == `OFS_IRQ_MASK);

	// read decode
	// unmapped offsets read zero
	wire ar_hs = s_axi_arvalid & arready_q;
	logic [7:0] rd_val;
	logic       rd_ok;
	always_comb begin
		rd_val = 8'h00;
		rd_ok  = 1'b1;
		if (s_axi_araddr == `OFS_SHUTDOWN_CONTROL) begin
			rd_val = {flag_q, ctrl_q[6:0]};
		end else if (s_axi_araddr == `OFS_SYNC_CONTROL) begin
			rd_val = sync_q;
		end else if (s_axi_araddr == `OFS_IRQ_STATUS) begin
			rd_val = stat_q;
		end else if (s_axi_araddr == `OFS_IRQ_MASK) begin
			rd_val = mask_q;
		end else begin
			rd_ok = 1'b0;
		end
	end

	// control fields
	assign fif.source_select              = ctrl_q[`BIT_SRC_HI:`BIT_SRC_LO];
	assign fif.comparator_one_sync_enable = sync_q[`BIT_CMP1_SYNC];
	assign fif.comparator_two_sync_enable = sync_q[`BIT_CMP2_SYNC];

	wire        auto_restart_enable    = sync_q[`BIT_AUTO_RESTART];
	wire        pin_tri_ac             = ctrl_q[`BIT_AC_HI];
	wire        pin_tri_bd             = ctrl_q[`BIT_BD_HI];
	wire        pin_lvl_ac             = ctrl_q[`BIT_AC_LO];
	wire        pin_lvl_bd             = ctrl_q[`BIT_BD_LO];

	// bit 7 written as zero asks for a clear, written as one forces shutdown unless auto-restart is on
	wire        sw_clear = wr_ctrl & ~wdat[`BIT_EVENT_FLAG];
	wire        sw_set   = wr_ctrl & wdat[`BIT_EVENT_FLAG];

	// source selection and the optional timer sync sit in the detector
	fault_detect u_fault_detect (
		.aclk                        (aclk),
		.aresetn                     (aresetn),
		.clk_en                      (clk_en),
		.comparator_one_async_output (comparator_one_async_output),
		.comparator_two_async_output (comparator_two_async_output),
		.fault_input_pin             (fault_input_pin),
		.timer1_sync_strobe          (timer1_sync_strobe),
		.fif                         (fif.det)
	);

	// event flag next value
	// a live condition always wins, so a clear never races a fault that is still present
	always_comb begin
		flag_d = flag_q;
		if (fif.condition) begin
			flag_d = 1'b1;
		end else if (auto_restart_enable) begin
			flag_d = 1'b0;
		end else if (sw_clear) begin
			flag_d = 1'b0;
		end else if (sw_set) begin
			flag_d = 1'b1;
		end
	end

	// pin shutdown levels and enables
	wire [3:0] sd_lvl;
	wire [3:0] sd_tri;
	assign sd_lvl[A] = pin_lvl_ac;
	assign sd_lvl[C] = pin_lvl_ac;
	assign sd_tri[A] = pin_tri_ac;
	assign sd_tri[C] = pin_tri_ac;
	assign sd_lvl[B] = pin_lvl_bd;
	assign sd_lvl[D] = pin_lvl_bd;
	assign sd_tri[B] = pin_tri_bd;
	assign sd_tri[D] = pin_tri_bd;
	// a released pin also has its level forced low, so it never shows a one
	// hold shutdown state
	wire [3:0] pout_d  = flag_q ? (sd_lvl & ~sd_tri) : pwm_in;
	wire [3:0] poe_n_d = flag_q ? sd_tri : 4'h0;

	// irq status: set on flag rising, write one clears, set wins
	wire       ev_rise = flag_d & ~flag_q;
	wire [7:0] stat_clr = wr_stat ? wdat : 8'h00;
	wire [7:0] stat_set = {7'h00, ev_rise};
	wire [7:0] stat_d   = (stat_q & ~stat_clr) | stat_set;

	// clk_en low freezes every register, bus handshakes included
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= `RST_SHUTDOWN_CONTROL;
			sync_q <= `RST_SYNC_CONTROL;
			stat_q <= `RST_IRQ;
			mask_q <= `RST_IRQ;
			flag_q <= 1'b0;
		end else if (clk_en) begin
			if (wr_ctrl) begin
				ctrl_q <= wdat;
			end
			if (wr_sync) begin
				sync_q <= {5'h00, wdat[2:0]};
			end
			if (wr_mask) begin
				mask_q <= {7'h00, wdat[`BIT_IRQ_EVENT]};
			end
			stat_q <= stat_d;
			flag_q <= flag_d;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pout_q  <= 4'h0;
			poe_n_q <= 4'hF;
			irq_q   <= 1'b0;
		end else if (clk_en) begin
			pout_q  <= pout_d;
			poe_n_q <= poe_n_d;
			irq_q   <= |(stat_d & mask_q);
		end
	end

	// axi write path
	// readies return only once the response has been taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q  <= 1'b0;
			w_got_q   <= 1'b0;
			awaddr_q  <= 8'h00;
			wdata_q   <= 8'h00;
			wstrb0_q  <= 1'b0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= `RESP_OKAY;
		end else if (clk_en) begin
			if (aw_hs) begin
				awaddr_q <= s_axi_awaddr;
			end
			if (w_hs) begin
				wdata_q  <= s_axi_wdata[7:0];
				wstrb0_q <= s_axi_wstrb[0];
			end
			aw_got_q  <= aw_have & ~do_write;
			w_got_q   <= w_have & ~do_write;
			awready_q <= ~aw_have & ~bvalid_q & ~do_write;
			wready_q  <= ~w_have & ~bvalid_q & ~do_write;
			if (do_write) begin
				bvalid_q <= 1'b1;
				bresp_q  <= w_mapped ? `RESP_OKAY : `RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q  <= 1'b0;
				awready_q <= 1'b1;
				wready_q  <= 1'b1;
			end
		end
	end

	// axi read path
	// arready stays low while an answer waits, so one read at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= `RESP_OKAY;
		end else if (clk_en) begin
			if (ar_hs) begin
				arready_q <= 1'b0;
				rvalid_q  <= 1'b1;
				rdata_q   <= {24'h00_0000, rd_val};
				rresp_q   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q  <= 1'b0;
				arready_q <= 1'b1;
			end else if (!rvalid_q) begin
				arready_q <= 1'b1;
			end
		end
	end

	assign s_axi_awready   = awready_q;
	assign s_axi_wready    = wready_q;
	assign s_axi_bvalid    = bvalid_q;
	assign s_axi_bresp     = bresp_q;
	assign s_axi_arready   = arready_q;
	assign s_axi_rvalid    = rvalid_q;
	assign s_axi_rdata     = rdata_q;
	assign s_axi_rresp     = rresp_q;
	assign pwm_output      = pout_q;
	assign pwm_output_oe_n = poe_n_q;
	assign shutdown_active = flag_q;
	assign irq             = irq_q;
endmodule : pwm_auto_shutdown

// ===== core/pwm_shutdown_params.svh
// offsets, field positions, reset values and codes for the auto-shutdown block
`ifndef PWM_SHUTDOWN_PARAMS_SVH
`define PWM_SHUTDOWN_PARAMS_SVH

`define OFS_SHUTDOWN_CONTROL 8'h00
`define OFS_SYNC_CONTROL     8'h04
`define OFS_IRQ_STATUS       8'h08
`define OFS_IRQ_MASK         8'h0C

`define BIT_EVENT_FLAG       7
`define BIT_SRC_HI           6
`define BIT_SRC_LO           4
`define BIT_AC_HI            3
`define BIT_AC_LO            2
`define BIT_BD_HI            1
`define BIT_BD_LO            0

`define BIT_CMP1_SYNC        0
`define BIT_CMP2_SYNC        1
`define BIT_AUTO_RESTART     2

`define BIT_IRQ_EVENT        0

`define RST_SHUTDOWN_CONTROL 8'h00
`define RST_SYNC_CONTROL     8'h00
`define RST_IRQ              8'h00

`define SRC_OFF              3'h0
`define SRC_CMP1             3'h1
`define SRC_CMP2             3'h2
`define SRC_CMP_ANY          3'h3
`define SRC_FAULT            3'h4
`define SRC_FAULT_CMP1       3'h5
`define SRC_FAULT_CMP2       3'h6
`define SRC_FAULT_ANY        3'h7

`define PIN_DRIVE_LOW        2'h0
`define PIN_DRIVE_HIGH       2'h1

`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

// ===== core/pwm_shutdown_pkg.sv
// types shared by the auto-shutdown block
package pwm_shutdown_pkg;
	typedef logic [2:0] src_sel_t;
	typedef logic [1:0] pin_state_t;
	typedef logic [7:0] reg8_t;
endpackage : pwm_shutdown_pkg

// ===== verification/fault_source_model.sv
// far-side model: comparators, fault pin and timer1 strobe
module fault_source_model (
	// clock
	input  wire logic       aclk,
	// requested faults: bit0 comparator one, bit1 comparator two, bit2 fault pin
	input  wire logic [2:0] want,
	input  wire logic       strobe_en,
	// outputs to the block
	output logic            cmp_one,
	output logic            cmp_two,
	output logic            fault_n,
	output logic            strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] cnt_q;
	// strobe once every eight cycles when enabled; one process drives every output
	initial begin
		{cmp_one, cmp_two, fault_n, strobe, cnt_q} = 7'h10;
		forever begin
			@(posedge aclk);
			cnt_q <= cnt_q + 3'h1;
			cmp_one <= want[0];
			cmp_two <= want[1];
			fault_n <= !want[2];
			strobe <= strobe_en && cnt_q == 3'h0;
		end
	end
endmodule : fault_source_model

// ===== verification/pwm_auto_shutdown_test.sv
// self-checking bench for the auto-shutdown block
module pwm_auto_shutdown_test;
	import pwm_shutdown_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb = 4'hF, pwm_in = 4'h0, pwm_output, pwm_output_oe_n;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic        shutdown_active, irq, f, strobe_en = 1'b0;
	logic        comparator_one_async_output, comparator_two_async_output, fault_input_pin, timer1_sync_strobe;
	logic [2:0]  want = 3'h0;
	int          miscompares = 0, checked = 0, ac, bd;

	always #2 aclk = ~aclk;

	fault_source_model src (.aclk(aclk), .want(want), .strobe_en(strobe_en), .cmp_one(comparator_one_async_output),
		.cmp_two(comparator_two_async_output), .fault_n(fault_input_pin), .strobe(timer1_sync_strobe));
	pwm_auto_shutdown dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .comparator_one_async_output(comparator_one_async_output),
		.comparator_two_async_output(comparator_two_async_output), .fault_input_pin(fault_input_pin),
		.timer1_sync_strobe(timer1_sync_strobe), .pwm_in(pwm_in), .pwm_output(pwm_output),
		.pwm_output_oe_n(pwm_output_oe_n), .shutdown_active(shutdown_active), .irq(irq));

	task automatic results;
		$display("checked %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results

	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	task automatic tmo(input int n);
		if (n >= 50) begin
			miscompares++;
			$display("mismatch handshake expected answer seen timeout");
			results();
		end
	endtask : tmo

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 50);
		s_axi_bready <= 1'b0;
		rsp = s_axi_bresp;
		tmo(n);
	endtask : wr

	task automatic rdr(input logic [7:0] a);
		int n;
		@(posedge aclk);
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 50);
		s_axi_rready <= 1'b0;
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		tmo(n);
	endtask : rdr

	// expected {oe_n, level} of pins a..d
	function automatic logic [7:0] pins(input logic sd, input int sac, input int sbd, input logic [3:0] p);
		int s;
		logic [3:0] o, e;
		for (int i = 0; i < 4; i++) begin
			s = (i % 2) ? sbd : sac;
			e[i] = sd && s >= 2;
			o[i] = sd ? (s == 1) : p[i];
		end
		return {e, o};
	endfunction : pins

	initial begin
		void'($urandom(11));
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		for (int a = 0; a < 20; a += 4) begin
			rdr(8'(a));
			cmp("reset value", 32'h0, rd);
			cmp("rresp", 32'((a == 16) ? 2 : 0), rsp);
		end
		wr(8'h10, 32'hFF);
		cmp("bresp", 32'h2, rsp);
		$display("test registers done");
		wr(8'h0C, 32'h1);
		cmp("bresp", 32'h0, rsp);
		wr(8'h04, 32'h4);
		for (int s = 0; s < 8; s++)
			for (int w = 0; w < 8; w++) begin
				ac = $urandom % 4;
				bd = $urandom % 4;
				pwm_in <= 4'($urandom);
				wr(8'h00, 32'(s * 16 + ac * 4 + bd));
				want <= 3'(w);
				repeat (7) @(posedge aclk);
				f = (s & w) != 0;
				cmp("flag", 32'(f), 32'(shutdown_active));
				cmp("pins", 32'(pins(f, ac, bd, pwm_in)), {pwm_output_oe_n, pwm_output});
				cmp("irq", 32'(f), 32'(irq));
				rdr(8'h00);
				cmp("control", {f, 3'(s), 2'(ac), 2'(bd)}, rd);
				want <= 3'h0;
				repeat (7) @(posedge aclk);
				cmp("flag", 32'h0, 32'(shutdown_active));
				wr(8'h08, 32'h1);
				repeat (3) @(posedge aclk);
				cmp("irq", 32'h0, 32'(irq));
			end
		$display("test sources done");
		wr(8'h04, 32'h0);
		wr(8'h00, 32'h4A);
		want <= 3'h4;
		repeat (7) @(posedge aclk);
		cmp("flag", 32'h1, 32'(shutdown_active));
		cmp("pins", 32'hF0, {pwm_output_oe_n, pwm_output});
		wr(8'h00, 32'h4A);
		repeat (3) @(posedge aclk);
		cmp("flag", 32'h1, 32'(shutdown_active));
		want <= 3'h0;
		repeat (7) @(posedge aclk);
		cmp("flag", 32'h1, 32'(shutdown_active));
		wr(8'h00, 32'h4A);
		repeat (3) @(posedge aclk);
		cmp("flag", 32'h0, 32'(shutdown_active));
		cmp("pins", 32'(pins(1'b0, 2, 2, pwm_in)), {pwm_output_oe_n, pwm_output});
		$display("test latch done");
		wr(8'h0C, 32'h0);
		repeat (3) @(posedge aclk);
		cmp("irq", 32'h0, 32'(irq));
		rdr(8'h08);
		cmp("status", 32'h1, rd);
		wr(8'h08, 32'h1);
		rdr(8'h08);
		cmp("status", 32'h0, rd);
		$display("test interrupt done");
		s_axi_wstrb <= 4'hE;
		wr(8'h00, 32'h80);
		cmp("bresp", 32'h0, rsp);
		s_axi_wstrb <= 4'hF;
		rdr(8'h00);
		cmp("control", 32'h4A, rd);
		wr(8'h00, 32'h80);
		repeat (3) @(posedge aclk);
		cmp("flag", 32'h1, 32'(shutdown_active));
		cmp("pins", 32'h00, {pwm_output_oe_n, pwm_output});
		wr(8'h00, 32'h00);
		repeat (3) @(posedge aclk);
		cmp("flag", 32'h0, 32'(shutdown_active));
		$display("test write done");
		for (int k = 1; k <= 2; k++) begin
			strobe_en <= 1'b0;
			want <= 3'h0;
			wr(8'h04, 32'(4 + k));
			wr(8'h00, 32'(16 * k));
			want <= 3'(k);
			repeat (8) @(posedge aclk);
			cmp("flag", 32'h0, 32'(shutdown_active));
			strobe_en <= 1'b1;
			repeat (16) @(posedge aclk);
			cmp("flag", 32'h1, 32'(shutdown_active));
		end
		$display("test sync done");
		wr(8'h04, 32'h4);
		clk_en <= 1'b0;
		want <= 3'h0;
		repeat (8) @(posedge aclk);
		cmp("frozen flag", 32'h1, 32'(shutdown_active));
		clk_en <= 1'b1;
		repeat (4) @(posedge aclk);
		cmp("flag", 32'h0, 32'(shutdown_active));
		$display("test freeze done");
		results();
	end
endmodule : pwm_auto_shutdown_test

// ===== verification/pwm_shutdown_monitor.sv
// port checker for the auto-shutdown block
module pwm_shutdown_monitor (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// bus handshakes
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// pins
	input wire logic [3:0]  pwm_in,
	input wire logic [3:0]  pwm_output,
	input wire logic [3:0]  pwm_output_oe_n,
	input wire logic        shutdown_active
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	AST_B_AFTER: assert property (s_wr_both |=> s_axi_bvalid) else $error("write response late");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	AST_R_AFTER: assert property (s_rd_taken |=> s_axi_rvalid) else $error("read data late");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
	AST_TRI_ZERO: assert property ((pwm_output & pwm_output_oe_n) == 4'h0)
		else $error("released pin shows one");
	AST_PAIRS: assert property ($past(shutdown_active) && $past(aresetn) |->
		pwm_output[0] == pwm_output[2] && pwm_output[1] == pwm_output[3] &&
		pwm_output_oe_n[0] == pwm_output_oe_n[2] && pwm_output_oe_n[1] == pwm_output_oe_n[3])
		else $error("shutdown pin pairs differ");
	AST_FOLLOW: assert property (!$past(shutdown_active) && $past(aresetn) |->
		pwm_output == $past(pwm_in) && pwm_output_oe_n == 4'h0) else $error("pins do not follow pwm");
endmodule : pwm_shutdown_monitor

bind pwm_auto_shutdown pwm_shutdown_monitor chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .pwm_in(pwm_in), .pwm_output(pwm_output),
	.pwm_output_oe_n(pwm_output_oe_n), .shutdown_active(shutdown_active));
